// ### rtl/ptpc_consts.svh
// Register map, field positions and reset values of the periodic timer.
`ifndef PTPC_CONSTS_SVH
`define PTPC_CONSTS_SVH

`define PTPC_OFF_CTRL   5'h00
`define PTPC_OFF_RUN    5'h04
`define PTPC_OFF_DUTY   5'h08
`define PTPC_OFF_PERIOD 5'h0c
`define PTPC_OFF_STATUS 5'h10
`define PTPC_OFF_COUNT  5'h14

`define PTPC_CTRL_RST   8'h00
`define PTPC_CNT_W      10
`define PTPC_CNT_MAX    10'h3ff
`define PTPC_ST_DUTY    0
`define PTPC_ST_PER     1

`endif

// ### rtl/ptpc_pkg.sv
// Types shared by the periodic timer modules.
`default_nettype none
package ptpc_pkg;

  typedef enum logic [1:0] {
    PTPC_MODE_CMP = 2'b00,
    PTPC_MODE_CAP = 2'b01,
    PTPC_MODE_PWM = 2'b10,
    PTPC_MODE_TMR = 2'b11
  } ptpc_mode_t;

  typedef enum logic [1:0] {
    PTPC_PF_LOW   = 2'b00,
    PTPC_PF_HIGH  = 2'b01,
    PTPC_PF_PWM   = 2'b10,
    PTPC_PF_PULSE = 2'b11
  } ptpc_pinfn_t;

  typedef enum logic [1:0] {
    PTPC_EDGE_RISE = 2'b00,
    PTPC_EDGE_FALL = 2'b01,
    PTPC_EDGE_BOTH = 2'b10,
    PTPC_EDGE_OFF  = 2'b11
  } ptpc_edge_t;

  typedef enum logic {
    PTPC_BUS_IDLE = 1'b0,
    PTPC_BUS_DONE = 1'b1
  } ptpc_bus_st_t;

  // Control byte in its register layout, bit 7 first.
  typedef struct packed {
    ptpc_mode_t mode;
    logic [1:0] pin_fn;
    logic       out_ctrl;
    logic       polarity;
    logic       cap_src;
    logic       clr_sel;
  } ptpc_ctrl_t;

  typedef struct packed {
    logic level;
    logic oe;
  } ptpc_pin_t;

endpackage
`default_nettype wire

// ### rtl/ptpc_edge.sv
// Edge detector for the synchronous timer input pins.
`default_nettype none
module ptpc_edge #(
  parameter int N = 2
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] rise_out,
  output logic      [N-1:0] fall_out
);

  logic [N-1:0] prev;

  // Each pin keeps its last level and compares it with the present one.
  for (genvar i = 0; i < N; i++) begin : g_pin
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        prev[i] <= 1'b0;
      end else if (ce_in) begin
        prev[i] <= pin_in[i];
      end
    end
    assign rise_out[i] = pin_in[i] & ~prev[i];
    assign fall_out[i] = ~pin_in[i] & prev[i];
  end

endmodule
`default_nettype wire

// ### rtl/ptpc_out.sv
// Output pin shaper for PWM and single pulse operation.
`default_nettype none
module ptpc_out
  import ptpc_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire ptpc_ctrl_t       ctrl_in,
  input  wire logic             run_in,
  input  wire logic [CNT_W-1:0] cnt_in,
  input  wire logic [CNT_W-1:0] duty_in,
  input  wire logic [CNT_W:0]   per_eff_in,
  output ptpc_pin_t             pin_out
);

  logic active;
  logic full;

  // Active state of the waveform before level and polarity are applied.
  always_comb begin
    full = {1'b0, duty_in} >= per_eff_in;
    case (ctrl_in.pin_fn)
      PTPC_PF_LOW:   active = 1'b0;
      PTPC_PF_HIGH:  active = 1'b1;
      PTPC_PF_PWM:   active = run_in & (full | (cnt_in < duty_in));
      PTPC_PF_PULSE: active = run_in;
      default:       active = 1'b0;
    endcase
  end

  // The pin is driven only in PWM or pulse mode; timer and capture leave it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= '0;
    end else if (ce_in) begin
      pin_out.oe <= (ctrl_in.mode == PTPC_MODE_PWM);
      // Output control picks active level, polarity inverts the result.
      pin_out.level <= (active ? ctrl_in.out_ctrl : ~ctrl_in.out_ctrl)
                       ^ ctrl_in.polarity;
    end
  end

endmodule
`default_nettype wire

// ### rtl/ptpc_top.sv
// Periodic timer with PWM, single pulse and capture on an Avalon slave.
`default_nettype none
`include "ptpc_consts.svh"
module ptpc_top
  import ptpc_pkg::*;
#(
  parameter int CNT_W = `PTPC_CNT_W
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        CE_IN,
  input  wire logic        TICK_IN,
  input  wire logic        CAPTURE_INPUT_PIN_IN,
  input  wire logic        EXTERNAL_TRIGGER_PIN_IN,
  input  wire logic [4:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  output logic             TIMER_OUTPUT_PIN_OUT,
  output logic             TIMER_OUTPUT_PIN_OE_OUT
);

  // Refuse counter widths the byte-lane write path cannot reach.
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("ptpc_top: CNT_W must lie between 2 and 16");
  end

  ptpc_ctrl_t       ctrl;
  logic             run;
  logic             run_prev;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] duty;
  logic [CNT_W-1:0] period;
  logic             duty_flag;
  logic             per_flag;
  ptpc_bus_st_t     bus_st;
  ptpc_pin_t        pin;

  logic             mode_pwm;
  logic             mode_pulse;
  logic             mode_cap;
  logic             mode_tmr;
  logic [CNT_W:0]   cnt_inc;
  logic [CNT_W:0]   per_eff;
  logic             run_rise;
  logic             step;
  logic             per_hit;
  logic             duty_hit;
  logic             per_clear;
  logic             duty_clear;
  logic             per_set;
  logic             duty_set;
  logic [1:0]       pin_rise;
  logic [1:0]       pin_fall;
  logic             src_rise;
  logic             src_fall;
  logic             cap_evt;
  logic             trig_set;
  logic             bus_wr;
  logic [15:0]      lane_mask;
  logic [15:0]      next_duty_w;
  logic [15:0]      next_per_w;
  logic [31:0]      next_rdata;

  // Mode decode; pulse mode is PWM mode with the pulse pin function.
  always_comb begin
    mode_pwm   = 1'b0;
    mode_pulse = 1'b0;
    mode_cap   = 1'b0;
    mode_tmr   = 1'b0;
    case (ctrl.mode)
      PTPC_MODE_CAP: mode_cap = 1'b1;
      PTPC_MODE_PWM: begin
        mode_pulse = (ctrl.pin_fn == PTPC_PF_PULSE);
        mode_pwm   = (ctrl.pin_fn != PTPC_PF_PULSE);
      end
      PTPC_MODE_TMR: mode_tmr = 1'b1;
      default:       mode_tmr = 1'b1;
    endcase
  end

  // A period value of zero stands for the full counter range.
  assign per_eff  = (period == '0) ? {1'b1, {CNT_W{1'b0}}}
                                   : {1'b0, period};
  assign cnt_inc  = {1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1};
  assign run_rise = run & ~run_prev;
  assign step     = TICK_IN & run & ~run_rise;

  // Comparators fire when the coming count reaches their value.
  assign per_hit  = step & (cnt_inc == per_eff);
  assign duty_hit = step & (duty != '0) & (cnt_inc == {1'b0, duty});

  // Clearing and flags per mode; pulse mode leaves period unused.
  assign per_clear  = per_hit & (mode_pwm | mode_cap
                    | (mode_tmr & ~ctrl.clr_sel));
  assign duty_clear = duty_hit & mode_tmr & ctrl.clr_sel;
  assign per_set    = per_clear;
  assign duty_set   = (duty_hit & ~mode_cap) | cap_evt;

  ptpc_edge #(
    .N (2)
  ) u_edge (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RESETN_IN),
    .ce_in    (CE_IN),
    .pin_in   ({EXTERNAL_TRIGGER_PIN_IN, CAPTURE_INPUT_PIN_IN}),
    .rise_out (pin_rise),
    .fall_out (pin_fall)
  );

  // Capture source and edge selection.
  always_comb begin
    src_rise = ctrl.cap_src ? pin_rise[1] : pin_rise[0];
    src_fall = ctrl.cap_src ? pin_fall[1] : pin_fall[0];
    case (ctrl.pin_fn)
      PTPC_EDGE_RISE: cap_evt = mode_cap & src_rise;
      PTPC_EDGE_FALL: cap_evt = mode_cap & src_fall;
      PTPC_EDGE_BOTH: cap_evt = mode_cap & (src_rise | src_fall);
      PTPC_EDGE_OFF:  cap_evt = 1'b0;
      default:        cap_evt = 1'b0;
    endcase
  end

  // A rising trigger pin edge starts a pulse like a software write.
  assign trig_set = mode_pulse & pin_rise[1];

  // Bus write takes effect at the edge that completes the transfer.
  assign bus_wr    = (bus_st == PTPC_BUS_DONE) & AVS_WRITE_IN;
  assign lane_mask = {{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
  assign next_duty_w = (16'(duty) & ~lane_mask)
                     | (AVS_WRITEDATA_IN[15:0] & lane_mask);
  assign next_per_w  = (16'(period) & ~lane_mask)
                     | (AVS_WRITEDATA_IN[15:0] & lane_mask);

  // Read data selection; unmapped offsets read as zero.
  always_comb begin
    case (AVS_ADDRESS_IN)
      `PTPC_OFF_CTRL:   next_rdata = {24'h0, ctrl};
      `PTPC_OFF_RUN:    next_rdata = {31'h0, run};
      `PTPC_OFF_DUTY:   next_rdata = 32'(duty);
      `PTPC_OFF_PERIOD: next_rdata = 32'(period);
      `PTPC_OFF_STATUS: next_rdata = {30'h0, per_flag, duty_flag};
      `PTPC_OFF_COUNT:  next_rdata = 32'(cnt);
      default:          next_rdata = 32'h0;
    endcase
  end

  // Slave handshake: one wait cycle, then waitrequest low for one cycle.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      bus_st              <= PTPC_BUS_IDLE;
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h0;
    end else if (CE_IN) begin
      case (bus_st)
        PTPC_BUS_IDLE: begin
          if (AVS_READ_IN || AVS_WRITE_IN) begin
            bus_st              <= PTPC_BUS_DONE;
            AVS_WAITREQUEST_OUT <= 1'b0;
            AVS_READDATA_OUT    <= next_rdata;
          end
        end
        PTPC_BUS_DONE: begin
          bus_st              <= PTPC_BUS_IDLE;
          AVS_WAITREQUEST_OUT <= 1'b1;
        end
        default: begin
          bus_st              <= PTPC_BUS_IDLE;
          AVS_WAITREQUEST_OUT <= 1'b1;
        end
      endcase
    end
  end

  // Control byte and period value are written only by software.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl   <= ptpc_ctrl_t'(`PTPC_CTRL_RST);
      period <= '0;
    end else if (CE_IN && bus_wr) begin
      if (AVS_ADDRESS_IN == `PTPC_OFF_CTRL && AVS_BYTEENABLE_IN[0]) begin
        ctrl <= ptpc_ctrl_t'(AVS_WRITEDATA_IN[7:0]);
      end
      if (AVS_ADDRESS_IN == `PTPC_OFF_PERIOD) begin
        period <= next_per_w[CNT_W-1:0];
      end
    end
  end

  // Run bit: software writes, a duty match ends a pulse, trigger wins.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      run      <= 1'b0;
      run_prev <= 1'b0;
    end else if (CE_IN) begin
      run_prev <= run;
      if (bus_wr && AVS_ADDRESS_IN == `PTPC_OFF_RUN
          && AVS_BYTEENABLE_IN[0]) begin
        run <= AVS_WRITEDATA_IN[0];
      end
      if (mode_pulse && duty_hit) begin
        run <= 1'b0;
      end
      if (trig_set) begin
        run <= 1'b1;
      end
    end
  end

  // Duty register: a capture outranks a software write.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      duty <= '0;
    end else if (CE_IN) begin
      if (cap_evt) begin
        duty <= cnt;
      end else if (bus_wr && AVS_ADDRESS_IN == `PTPC_OFF_DUTY) begin
        duty <= next_duty_w[CNT_W-1:0];
      end
    end
  end

  // Counter: zeroed on run rising, then steps on ticks while running.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt <= '0;
    end else if (CE_IN) begin
      if (run_rise) begin
        cnt <= '0;
      end else if (step) begin
        if (per_clear || duty_clear) begin
          cnt <= '0;
        end else begin
          cnt <= cnt_inc[CNT_W-1:0];
        end
      end
    end
  end

  // Sticky match flags; writing one clears, a same-cycle event wins.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      duty_flag <= 1'b0;
      per_flag  <= 1'b0;
    end else if (CE_IN) begin
      if (bus_wr && AVS_ADDRESS_IN == `PTPC_OFF_STATUS
          && AVS_BYTEENABLE_IN[0]) begin
        if (AVS_WRITEDATA_IN[`PTPC_ST_DUTY]) begin
          duty_flag <= 1'b0;
        end
        if (AVS_WRITEDATA_IN[`PTPC_ST_PER]) begin
          per_flag <= 1'b0;
        end
      end
      if (duty_set) begin
        duty_flag <= 1'b1;
      end
      if (per_set) begin
        per_flag <= 1'b1;
      end
    end
  end

  ptpc_out #(
    .CNT_W (CNT_W)
  ) u_out (
    .clk_in     (CLK_SYS_IN),
    .rst_n_in   (RESETN_IN),
    .ce_in      (CE_IN),
    .ctrl_in    (ctrl),
    .run_in     (run),
    .cnt_in     (cnt),
    .duty_in    (duty),
    .per_eff_in (per_eff),
    .pin_out    (pin)
  );

  assign TIMER_OUTPUT_PIN_OUT    = pin.level;
  assign TIMER_OUTPUT_PIN_OE_OUT = pin.oe;

  // Checks on the timer behaviour, all in the system clock domain.
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESETN_IN);

  // Pulse start: run rises in pulse mode.
  sequence s_pulse_start;
    CE_IN && mode_pulse && run_rise;
  endsequence

  // Pulse end: the duty comparator fires while the pulse runs.
  sequence s_pulse_match;
    CE_IN && mode_pulse && duty_hit && !trig_set;
  endsequence

  a_timer_pin_free:
    assert property (CE_IN && mode_tmr |=> !TIMER_OUTPUT_PIN_OE_OUT)
      else $error("Timer mode drives the output pin.");

  a_capture_no_out:
    assert property (CE_IN && mode_cap |=> !TIMER_OUTPUT_PIN_OE_OUT)
      else $error("Capture mode drives the output pin.");

  a_pwm_period_wrap:
    assert property (CE_IN && mode_pwm && per_hit
                     |=> cnt == '0 && per_flag)
      else $error("PWM period match did not clear the counter.");

  a_pwm_full_range:
    assert property (CE_IN && mode_pwm && step && period == '0
                     && cnt == '1 |=> cnt == '0)
      else $error("Zero period did not give the full PWM range.");

  a_pwm_full_duty:
    assert property (CE_IN && mode_pwm && run && period != '0
                     && ctrl.pin_fn == PTPC_PF_PWM && duty >= period
                     |=> TIMER_OUTPUT_PIN_OUT
                         == $past(ctrl.out_ctrl ^ ctrl.polarity))
      else $error("Full duty PWM output left the active level.");

  a_pulse_lead_edge:
    assert property (s_pulse_start |=> TIMER_OUTPUT_PIN_OE_OUT
                     && TIMER_OUTPUT_PIN_OUT
                        == $past(ctrl.out_ctrl ^ ctrl.polarity))
      else $error("Run rising gave no pulse leading edge.");

  a_pulse_trigger:
    assert property (CE_IN && trig_set |=> run)
      else $error("Trigger edge did not set the run bit.");

  a_pulse_end_flag:
    assert property (s_pulse_match |=> !run && duty_flag ##1
                     (!$past(CE_IN) || TIMER_OUTPUT_PIN_OUT
                      != ($past(ctrl.out_ctrl, 2) ^ $past(ctrl.polarity, 2))))
      else $error("Duty match did not end the pulse.");

  a_run_rise_zero:
    assert property (CE_IN && run_rise |=> cnt == '0)
      else $error("Run rising did not zero the counter.");

  a_capture_copy:
    assert property (CE_IN && cap_evt |=> duty == $past(cnt) && duty_flag)
      else $error("Capture edge did not copy the counter.");

  a_capture_off:
    assert property (CE_IN && mode_cap && ctrl.pin_fn == PTPC_EDGE_OFF
                     && !bus_wr |=> $stable(duty))
      else $error("Disabled capture changed the capture value.");

  a_stopped_hold:
    assert property (CE_IN && !run |=> $stable(cnt))
      else $error("Counter moved while the run bit was low.");

  a_flag_set_wins:
    assert property (CE_IN && per_set |=> per_flag)
      else $error("Period match flag lost to a clear.");

endmodule
`default_nettype wire

// ### tb/ptpc_pins_model.sv
// Pulse sources, tick source and pulled-up load on the timer's pins.
`default_nettype none
module ptpc_pins_model (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic tick_en_in,
  input  wire logic cap_lvl_in,
  input  wire logic trig_lvl_in,
  input  wire logic pin_in,
  input  wire logic pin_oe_in,
  output logic      tick_out,
  output logic      cap_pin_out,
  output logic      trig_pin_out,
  output logic      pad_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // The sources change their levels on a clock edge, one cycle after their inputs.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_out     <= 1'b0;
      cap_pin_out  <= 1'b0;
      trig_pin_out <= 1'b0;
    end else begin
      tick_out     <= tick_en_in;
      cap_pin_out  <= cap_lvl_in;
      trig_pin_out <= trig_lvl_in;
    end
  end

  // The load pulls the pad high whenever the timer lets go of the pin.
  assign pad_out = pin_oe_in ? pin_in : 1'b1;
endmodule
`default_nettype wire

// ### tb/ptpc_tb_top.sv
// Self-checking bench for the periodic timer over its Avalon slave port.
`default_nettype none
`include "ptpc_consts.svh"
module ptpc_tb_top
  import ptpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst_n, tick_en, cap_lvl, trig_lvl, rd, wr, ce;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, q, c0, c1;
  logic        waitrq, pin, oe, tick, cap_pin, trig_pin, pad;
  int          bad_count, checks;

  ptpc_top u_ptpc_top (
    .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce), .TICK_IN(tick),
    .CAPTURE_INPUT_PIN_IN(cap_pin), .EXTERNAL_TRIGGER_PIN_IN(trig_pin),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitrq),
    .TIMER_OUTPUT_PIN_OUT(pin), .TIMER_OUTPUT_PIN_OE_OUT(oe));

  ptpc_pins_model u_ptpc_pins_model (
    .clk_in(clk), .rst_n_in(rst_n), .tick_en_in(tick_en),
    .cap_lvl_in(cap_lvl), .trig_lvl_in(trig_lvl), .pin_in(pin),
    .pin_oe_in(oe), .tick_out(tick), .cap_pin_out(cap_pin),
    .trig_pin_out(trig_pin), .pad_out(pad));

  // Free-running system clock of 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compares a value exactly.
  task automatic check_eq(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Compares a value against an inclusive range.
  task automatic check_rng(string name, int lo, int hi, logic [31:0] got);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %h", name, lo, hi, got);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    addr  <= a;
    wdata <= d;
    rd    <= ~w;
    wr    <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrq !== 1'b0 && n < 50);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      finish_test();
    end
    @(posedge clk);
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  // Packs the control fields through the package type and writes them.
  task automatic set_ctrl(input ptpc_mode_t m, input logic [1:0] pf,
                          input logic oc, input logic pol,
                          input logic src, input logic clr);
    ptpc_ctrl_t c;
    c = '{mode: m, pin_fn: pf, out_ctrl: oc, polarity: pol,
          cap_src: src, clr_sel: clr};
    wr_reg(`PTPC_OFF_CTRL, {24'h0, c});
  endtask

  // Counts the cycles in which the pad is high.
  task automatic count_high(input int n, output logic [31:0] r);
    r = 32'h0;
    repeat (n) begin
      @(posedge clk);
      r = r + {31'h0, pad};
    end
  endtask

  // Restarts the counter with a fresh run edge.
  task automatic restart();
    wr_reg(`PTPC_OFF_RUN, 32'h0);
    wr_reg(`PTPC_OFF_RUN, 32'h1);
  endtask

  initial begin
    rst_n = 1'b0; tick_en = 1'b0; cap_lvl = 1'b0; trig_lvl = 1'b0;
    rd = 1'b0; wr = 1'b0; addr = 5'h00; wdata = 32'h0;
    bad_count = 0; checks = 0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset state and an unmapped address.
    check_eq("oe_reset", 32'h0, {31'h0, oe});
    rd_reg(`PTPC_OFF_COUNT, q); check_eq("count_reset", 32'h0, q);
    wr_reg(5'h18, 32'hffffffff);
    rd_reg(5'h18, q); check_eq("unmapped", 32'h0, q);
    // Timer mode: flags like compare mode, pin left undriven.
    set_ctrl(PTPC_MODE_TMR, 2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
    wr_reg(`PTPC_OFF_DUTY, 32'h3);
    wr_reg(`PTPC_OFF_PERIOD, 32'h5);
    tick_en <= 1'b1;
    restart();
    repeat (30) @(posedge clk);
    check_eq("tmr_oe", 32'h0, {31'h0, oe});
    rd_reg(`PTPC_OFF_STATUS, q); check_eq("tmr_flags", 32'h3, q);
    rd_reg(`PTPC_OFF_COUNT, q); check_rng("tmr_count", 0, 4, q);
    tick_en <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(`PTPC_OFF_COUNT, c0);
    repeat (10) @(posedge clk);
    rd_reg(`PTPC_OFF_COUNT, q); check_eq("tick_hold", c0, q);
    // PWM: every level and polarity pairing, clear select varied.
    tick_en <= 1'b1;
    wr_reg(`PTPC_OFF_PERIOD, 32'h8);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`PTPC_OFF_RUN, 32'h0);
      set_ctrl(PTPC_MODE_PWM, PTPC_PF_PWM, i[0], i[1], 1'b0, i[0]);
      restart();
      repeat (20) @(posedge clk);
      count_high(64, q);
      check_eq("pwm_high", (i[0] ^ i[1]) ? 32'd24 : 32'd40, q);
    end
    // Forced levels keep the comparators running.
    for (int f = 0; f < 2; f++) begin
      set_ctrl(PTPC_MODE_PWM, f[1:0], 1'b1, 1'b0, 1'b0, 1'b0);
      wr_reg(`PTPC_OFF_STATUS, 32'h3);
      repeat (20) @(posedge clk);
      count_high(16, q); check_eq("forced", f ? 32'd16 : 32'd0, q);
      rd_reg(`PTPC_OFF_STATUS, q); check_eq("pwm_flags", 32'h3, q);
    end
    // Duty equal to the period gives full duty.
    set_ctrl(PTPC_MODE_PWM, PTPC_PF_PWM, 1'b1, 1'b0, 1'b0, 1'b0);
    wr_reg(`PTPC_OFF_DUTY, 32'h8);
    repeat (20) @(posedge clk);
    count_high(64, q); check_eq("full_duty", 32'd64, q);
    // A zero period stretches the period to 1024 counts.
    wr_reg(`PTPC_OFF_PERIOD, 32'h0);
    wr_reg(`PTPC_OFF_DUTY, 32'd1000);
    restart();
    repeat (20) @(posedge clk);
    count_high(2048, q); check_eq("per_1024", 32'd2000, q);
    // Single pulse from software, ended by the duty match.
    wr_reg(`PTPC_OFF_RUN, 32'h0);
    wr_reg(`PTPC_OFF_DUTY, 32'h6);
    wr_reg(`PTPC_OFF_PERIOD, 32'h2);
    set_ctrl(PTPC_MODE_PWM, PTPC_PF_PULSE, 1'b1, 1'b0, 1'b0, 1'b1);
    wr_reg(`PTPC_OFF_STATUS, 32'h3);
    wr_reg(`PTPC_OFF_RUN, 32'h1);
    count_high(40, q); check_rng("pulse_w", 5, 8, q);
    rd_reg(`PTPC_OFF_RUN, q); check_eq("run_clr", 32'h0, q);
    rd_reg(`PTPC_OFF_STATUS, q); check_eq("pulse_flag", 32'h1, q);
    rd_reg(`PTPC_OFF_COUNT, c0); check_rng("stop_cnt", 1, 1023, c0);
    repeat (10) @(posedge clk);
    rd_reg(`PTPC_OFF_COUNT, q); check_eq("stop_hold", c0, q);
    // The trigger pin starts the pulse by itself.
    trig_lvl <= 1'b1;
    count_high(40, q); check_rng("trig_w", 5, 8, q);
    trig_lvl <= 1'b0;
    // A software clear cuts a long pulse short.
    wr_reg(`PTPC_OFF_DUTY, 32'd200);
    wr_reg(`PTPC_OFF_RUN, 32'h1);
    repeat (5) @(posedge clk);
    check_eq("pulse_on", 32'h1, {31'h0, pad});
    wr_reg(`PTPC_OFF_RUN, 32'h0);
    repeat (3) @(posedge clk);
    check_eq("pulse_off", 32'h0, {31'h0, pad});
    // Capture with a zero period runs to the top and wraps.
    set_ctrl(PTPC_MODE_CAP, PTPC_EDGE_RISE, 1'b1, 1'b1, 1'b0, 1'b1);
    wr_reg(`PTPC_OFF_PERIOD, 32'h0);
    restart();
    repeat (500) @(posedge clk);
    // A low clock enable freezes the counter for 100 of these cycles.
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    repeat (500) @(posedge clk);
    rd_reg(`PTPC_OFF_COUNT, q); check_rng("cap_top", 990, 1023, q);
    repeat (40) @(posedge clk);
    rd_reg(`PTPC_OFF_COUNT, q); check_rng("cap_wrap", 0, 40, q);
    check_eq("cap_oe", 32'h0, {31'h0, oe});
    wr_reg(`PTPC_OFF_PERIOD, 32'h4);
    restart();
    wr_reg(`PTPC_OFF_STATUS, 32'h3);
    repeat (20) @(posedge clk);
    rd_reg(`PTPC_OFF_STATUS, q); check_eq("ovf_flag", 32'h2, q & 32'h2);
    rd_reg(`PTPC_OFF_COUNT, q); check_rng("ovf_cnt", 0, 3, q);
    // Every edge code on both sources with the counter frozen.
    wr_reg(`PTPC_OFF_PERIOD, 32'h0);
    tick_en <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(`PTPC_OFF_COUNT, c0);
    for (int e = 0; e < 4; e++) begin
      for (int s = 0; s < 2; s++) begin
        set_ctrl(PTPC_MODE_CAP, e[1:0], 1'b0, 1'b0, s[0], 1'b0);
        wr_reg(`PTPC_OFF_DUTY, 32'h0);
        wr_reg(`PTPC_OFF_STATUS, 32'h3);
        if (s) cap_lvl <= 1'b1;
        else trig_lvl <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(`PTPC_OFF_DUTY, q); check_eq("cap_other", 32'h0, q);
        if (s) trig_lvl <= 1'b1;
        else cap_lvl <= 1'b1;
        repeat (3) @(posedge clk);
        c1 = (e == 0 || e == 2) ? c0 : 32'h0;
        rd_reg(`PTPC_OFF_DUTY, q); check_eq("cap_rise", c1, q);
        wr_reg(`PTPC_OFF_DUTY, 32'h0);
        cap_lvl <= 1'b0;
        trig_lvl <= 1'b0;
        repeat (3) @(posedge clk);
        c1 = (e == 1 || e == 2) ? c0 : 32'h0;
        rd_reg(`PTPC_OFF_DUTY, q); check_eq("cap_fall", c1, q);
        c1 = (e != 3) ? 32'h1 : 32'h0;
        rd_reg(`PTPC_OFF_STATUS, q); check_eq("cap_flag", c1, q);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
